// file: host_model.sv
// Purpose: host model that writes and reads the intensity registers
// Assumes: requests change at the falling edge of core_clk
// Notes: idle data lines carry inverted junk, never the last value
`timescale 1ns/1ps

module host_model
  import led_pwm_pkg::*;
(
  // clock
  input wire logic core_clk,
  // register access
  output reg_req_type reg_req,
  input wire logic [7:0] reg_rd_data_q
);
  initial reg_req = '0;

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    reg_req = '{wr_en: 1'b1, addr: a, data: d};
    @(negedge core_clk);
    reg_req.wr_en = 1'b0;
    reg_req.data = ~d;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge core_clk);
    reg_req.addr = a;
    @(negedge core_clk);
    d = reg_rd_data_q;
  endtask : rd
endmodule : host_model

// file: intensity_bank.sv
// Purpose: storage for the per-output intensity registers
// Assumes: one write per cycle, all entries visible in parallel
// Notes: entry k holds two nibbles, low nibble for the even output
`timescale 1ns/1ps

module intensity_bank
  import led_pwm_pkg::*;
#(
  parameter int NREG = INTENSITY_REGS
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // write port
  input wire logic wr_en,
  input wire logic [2:0] wr_idx,
  input wire logic [7:0] wr_data,
  // contents
  output logic [NREG*8-1:0] regs_q
);

  logic [NREG*8-1:0] regs_d;

  genvar k;
  generate
    for (k = 0; k < NREG; k++) begin : g_entry
      always_comb begin
        regs_d[k*8 +: 8] = regs_q[k*8 +: 8];
        if (wr_en && (wr_idx == 3'(k))) begin
          regs_d[k*8 +: 8] = wr_data;
        end
      end
    end
  endgenerate

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      regs_q <= {NREG{INTENSITY_RESET}};
    end else begin
      regs_q <= regs_d;
    end
  end

endmodule : intensity_bank

// file: led_pwm_intensity_control.sv
// Purpose: pwm intensity engine for 16 open-drain outputs plus the extra output
// Assumes: register requests and blink controls synchronous to core_clk
// Notes: outputs are open drain; port_oe_q high means the pin is pulled low
`timescale 1ns/1ps

module led_pwm_intensity_control
  import led_pwm_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // register access
  input wire reg_req_type reg_req,
  output logic [7:0] reg_rd_data_q,
  // configuration and blink phase bits
  input wire logic global_intensity_en,
  input wire blink_ctrl_type blink,
  // open-drain outputs and pwm activity flag
  output logic [PORTS-1:0] port_out_q,
  output logic [PORTS-1:0] port_oe_q,
  output logic pwm_active_q
);

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [7:0] master_q, master_d;
  logic [7:0] rd_data_d;
  logic [INTENSITY_REGS*8-1:0] bank_regs;
  logic bank_wr;

  assign bank_wr = reg_req.wr_en && (reg_req.addr >= INTENSITY_FIRST_ADDR)
                   && (reg_req.addr <= INTENSITY_LAST_ADDR);

  intensity_bank #(.NREG(INTENSITY_REGS)) u_bank (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .wr_en(bank_wr),
    .wr_idx(reg_req.addr[2:0]),
    .wr_data(reg_req.data),
    .regs_q(bank_regs)
  );

  always_comb begin
    master_d = master_q;
    if (reg_req.wr_en && (reg_req.addr == MASTER_ADDR)) begin
      master_d = reg_req.data;
    end
    rd_data_d = 8'h00;
    if (reg_req.addr == MASTER_ADDR) begin
      rd_data_d = master_q;
    end else if ((reg_req.addr >= INTENSITY_FIRST_ADDR)
                 && (reg_req.addr <= INTENSITY_LAST_ADDR)) begin
      rd_data_d = bank_regs[reg_req.addr[2:0]*8 +: 8];
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      master_q <= MASTER_RESET;
      reg_rd_data_q <= 8'h00;
    end else begin
      master_q <= master_d;
      reg_rd_data_q <= rd_data_d;
    end
  end

  // ----------------------------------------
  // pwm timebase
  // ----------------------------------------
  logic run;
  logic [OSC_DIV_W-1:0] div_q, div_d;
  logic [3:0] cyc_q, cyc_d;
  logic [3:0] slot_q, slot_d;
  logic tick;
  logic boundary;

  // any nonzero master nibble starts pwm
  assign run = master_q[MASTER_FIELD_LSB +: 4] != 4'h0;
  assign tick = run && (div_q == OSC_DIV_W'(OSC_DIV_CYCLES - 1));
  assign boundary = tick && (cyc_q == LAST_CYCLE) && (slot_q == LAST_SLOT);

  always_comb begin
    div_d = div_q;
    cyc_d = cyc_q;
    slot_d = slot_q;
    if (!run) begin
      // tick source parked to save power while all outputs are static
      div_d = '0;
      cyc_d = 4'h0;
      slot_d = 4'h0;
    end else if (tick) begin
      div_d = '0;
      cyc_d = cyc_q + 4'h1;
      if (cyc_q == LAST_CYCLE) begin
        slot_d = (slot_q == LAST_SLOT) ? 4'h0 : slot_q + 4'h1;
      end
    end else begin
      div_d = div_q + OSC_DIV_W'(1);
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      div_q <= '0;
      cyc_q <= 4'h0;
      slot_q <= 4'h0;
    end else begin
      div_q <= div_d;
      cyc_q <= cyc_d;
      slot_q <= slot_d;
    end
  end

  // ----------------------------------------
  // settings snapshot
  // ----------------------------------------
  logic [PORTS-1:0][3:0] eff_n;
  logic [PORTS-1:0][3:0] lvl_q, lvl_d;
  logic [3:0] mst_q, mst_d;
  logic run_q;
  logic start;

  // a fresh period must load the new master value at once, not a full period later
  assign start = run && !run_q;

  // global mode routes the extra output nibble to every output
  genvar i;
  generate
    for (i = 0; i < PORTS; i++) begin : g_eff
      if (i == PORTS - 1) begin : g_extra
        assign eff_n[i] = master_q[EXTRA_FIELD_LSB +: 4];
      end else begin : g_port
        assign eff_n[i] = global_intensity_en ? master_q[EXTRA_FIELD_LSB +: 4]
                                              : bank_regs[i*4 +: 4];
      end
    end
  endgenerate

  // mid-period changes would cut pulses short, so they wait for the wrap
  always_comb begin
    lvl_d = lvl_q;
    mst_d = mst_q;
    if (!run || boundary || start) begin
      lvl_d = eff_n;
      mst_d = master_q[MASTER_FIELD_LSB +: 4];
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      lvl_q <= {PORTS{INTENSITY_RESET[3:0]}};
      mst_q <= MASTER_RESET[7:4];
      run_q <= 1'b0;
    end else begin
      lvl_q <= lvl_d;
      mst_q <= mst_d;
      run_q <= run;
    end
  end

  // ----------------------------------------
  // output drive
  // ----------------------------------------
  logic [PORTS-1:0] sel_bits;
  logic [PORTS-1:0] drive_low_d;
  logic pwm_active_d;

  // the active blink phase chooses the polarity
  assign sel_bits = (blink.enable && blink.flip) ? blink.phase1 : blink.phase0;
  assign pwm_active_d = mst_q != 4'h0;

  generate
    for (i = 0; i < PORTS; i++) begin : g_drive
      always_comb begin
        logic active;
        active = (slot_q < mst_q) && (cyc_q <= lvl_q[i]);
        if (!run || (mst_q == 4'h0) || (lvl_q[i] == STATIC_LEVEL)) begin
          drive_low_d[i] = ~sel_bits[i];
        end else begin
          drive_low_d[i] = active ^ sel_bits[i];
        end
      end
    end
  endgenerate

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      port_oe_q <= '0;
      port_out_q <= '0;
      pwm_active_q <= 1'b0;
    end else begin
      port_oe_q <= drive_low_d;
      port_out_q <= '0;
      pwm_active_q <= pwm_active_d;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  chk_static_follow: assert property (@(posedge core_clk) disable iff (sys_rst)
    (!run && $past(!run) && !$past(sys_rst)) |-> (port_oe_q == $past(~sel_bits)))
    else $error("static output does not follow phase bits");

  chk_osc_stopped: assert property (@(posedge core_clk) disable iff (sys_rst)
    !run |=> (div_q == '0) && (cyc_q == 4'h0) && (slot_q == 4'h0))
    else $error("pwm timebase runs while pwm is off");

  chk_tick_spacing: assert property (@(posedge core_clk) disable iff (sys_rst)
    (run && $past(run) && (div_q == '0) && ($past(div_q) != '0))
      |-> $past(div_q) == OSC_DIV_W'(OSC_DIV_CYCLES - 1))
    else $error("tick spacing wrong");

  chk_period_wrap: assert property (@(posedge core_clk) disable iff (sys_rst)
    boundary && run ##1 run |-> (slot_q == 4'h0) && (cyc_q == 4'h0))
    else $error("period does not wrap after 15 slots");

  chk_slot_limit: assert property (@(posedge core_clk) disable iff (sys_rst)
    slot_q <= LAST_SLOT)
    else $error("slot counter beyond last slot");

  chk_shadow_hold: assert property (@(posedge core_clk) disable iff (sys_rst)
    (run && !boundary && !start) |=> $stable(lvl_q) && $stable(mst_q))
    else $error("settings changed inside a period");

  chk_gate_off: assert property (@(posedge core_clk) disable iff (sys_rst)
    (run && mst_q != 4'h0 && slot_q >= mst_q && lvl_q[0] != STATIC_LEVEL)
      |=> port_oe_q[0] == $past(sel_bits[0]))
    else $error("output active outside gated slots");

  chk_full_level: assert property (@(posedge core_clk) disable iff (sys_rst)
    (lvl_q[0] == STATIC_LEVEL) |=> port_oe_q[0] == $past(~sel_bits[0]))
    else $error("level 0xf not static");

  chk_duty_low: assert property (@(posedge core_clk) disable iff (sys_rst)
    (run && mst_q != 4'h0 && slot_q < mst_q && lvl_q[1] != STATIC_LEVEL && cyc_q <= lvl_q[1])
      |=> port_oe_q[1] == $past(~sel_bits[1]))
    else $error("on-time polarity wrong");

  chk_global_use: assert property (@(posedge core_clk) disable iff (sys_rst)
    (global_intensity_en && (!run || boundary)) |=> lvl_q[3] == $past(master_q[3:0]))
    else $error("global level not applied");

endmodule : led_pwm_intensity_control

// file: led_pwm_pkg.sv
// Purpose: constants and carrier types for the led pwm intensity block
// Assumes: 40 MHz core clock, register access from a serial slave elsewhere
// Notes: one nibble per output; the extra output uses the low master nibble
//
// Overview of operation
// - master register 0x00..0x0f: pwm off, every output static
// - static mode ignores global flag and registers 0x10..0x17
// - master register 0x10..0xff: pwm timing runs
// - individual mode: level 0xf gives static glitch-free output
// - individual mode: levels 0x0..0xe are pulse-width modulated
// - global flag set: one shared level for all outputs
// - global mode consults only register 0x0e, per-output registers ignored
// - level n: low (n+1)/16, released rest; phase bit 1 swaps
// - level 0xf: static low for bit 0, released for bit 1
// - blink enabled: active blink phase bit picks polarity
// - extra output nibble doubles as the global level
// - global mode replaces all 16 individual levels
// - master and global nibbles act as one 240-step control
// - global mode always covers every output, never a subset
// - period is 15 timeslots of 16 pwm cycles, 240 steps
// - master nibble gates individual levels into 1..15 timeslots
// - level 16/16 ignores master gate, follows phase bit statically
// - pwm timing from nominal 32 kHz tick, stopped when pwm off

package led_pwm_pkg;

  // ----------------------------------------
  // clocking
  // ----------------------------------------
  localparam int CLK_HZ = 40_000_000;
  localparam int PWM_OSC_HZ = 32_000;
  localparam int OSC_DIV_CYCLES = CLK_HZ / PWM_OSC_HZ;
  localparam int OSC_DIV_W = $clog2(OSC_DIV_CYCLES);

  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [7:0] MASTER_ADDR = 8'h0e;
  localparam logic [7:0] INTENSITY_FIRST_ADDR = 8'h10;
  localparam logic [7:0] INTENSITY_LAST_ADDR = 8'h17;
  localparam int INTENSITY_REGS = 8;
  localparam int MASTER_FIELD_LSB = 4;
  localparam int EXTRA_FIELD_LSB = 0;
  localparam logic [7:0] MASTER_RESET = 8'h00;
  localparam logic [7:0] INTENSITY_RESET = 8'hff;

  // ----------------------------------------
  // pwm timing
  // ----------------------------------------
  localparam int PORTS = 17;
  localparam logic [3:0] STATIC_LEVEL = 4'hf;
  localparam logic [3:0] LAST_CYCLE = 4'hf;
  localparam logic [3:0] LAST_SLOT = 4'he;

  // ----------------------------------------
  // carriers
  // ----------------------------------------
  typedef struct packed {
    logic wr_en;
    logic [7:0] addr;
    logic [7:0] data;
  } reg_req_type;

  typedef struct packed {
    logic enable;
    logic flip;
    logic [PORTS-1:0] phase0;
    logic [PORTS-1:0] phase1;
  } blink_ctrl_type;

endpackage : led_pwm_pkg

// file: tb_top.sv
// Purpose: self-checking bench for the led pwm intensity block
// Assumes: one pwm slot is 16 ticks of OSC_DIV_CYCLES core cycles
// Notes: duty counts allow a few cycles of slack at window edges
`timescale 1ns/1ps

module tb_top;
  import led_pwm_pkg::*;
  localparam int OSC = OSC_DIV_CYCLES;
  localparam int SLOT = 16 * OSC;
  logic core_clk, sys_rst, global_intensity_en, pwm_active_q;
  blink_ctrl_type blink;
  reg_req_type reg_req;
  logic [7:0] reg_rd_data_q, rd_v;
  logic [PORTS-1:0] port_out_q, port_oe_q;
  int err_total, compares, cyc;
  int cnt [PORTS];

  led_pwm_intensity_control DUT (.core_clk(core_clk), .sys_rst(sys_rst), .reg_req(reg_req),
    .reg_rd_data_q(reg_rd_data_q), .global_intensity_en(global_intensity_en),
    .blink(blink), .port_out_q(port_out_q), .port_oe_q(port_oe_q),
    .pwm_active_q(pwm_active_q));
  host_model host (.core_clk(core_clk), .reg_req(reg_req), .reg_rd_data_q(reg_rd_data_q));

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  // whole run is about 63000 cycles
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      err_total = err_total + 1;
      stop_test();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // slack covers the few cycles lost while the window opens
  task automatic near(input int got, input int exp);
    compares++;
    if (got < exp - 4 || got > exp + 4) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : near

  task automatic measure(input int w);
    foreach (cnt[i]) cnt[i] = 0;
    repeat (w) begin
      @(negedge core_clk);
      for (int i = 0; i < PORTS; i++) cnt[i] += int'(port_oe_q[i] === 1'b1);
    end
  endtask : measure

  task automatic wait_pwm;
    int n;
    n = 0;
    while (pwm_active_q !== 1'b1 && n < 20) begin
      @(negedge core_clk);
      n++;
    end
    chk(pwm_active_q, 1'b1);
  endtask : wait_pwm

  task automatic t_static;
    host.rd(MASTER_ADDR, rd_v);
    chk(rd_v, MASTER_RESET);
    host.rd(INTENSITY_FIRST_ADDR, rd_v);
    chk(rd_v, INTENSITY_RESET);
    host.rd(8'h20, rd_v);
    chk(rd_v, 8'h00);
    global_intensity_en = 1'b1;
    host.wr(MASTER_ADDR, 8'h0f);
    host.wr(INTENSITY_FIRST_ADDR, 8'h00);
    host.rd(MASTER_ADDR, rd_v);
    chk(rd_v, 8'h0f);
    measure(3000);
    chk(pwm_active_q, 1'b0);
    chk(cnt[0], 3000);
    chk(cnt[3], 0);
    chk(port_out_q, '0);
  endtask : t_static

  task automatic t_individual;
    global_intensity_en = 1'b0;
    host.wr(8'h11, 8'h00);
    host.wr(INTENSITY_FIRST_ADDR, 8'hf2);
    host.wr(MASTER_ADDR, 8'h12);
    wait_pwm();
    // a level change in mid-period must wait for the boundary
    host.wr(INTENSITY_FIRST_ADDR, 8'hf0);
    measure(2 * SLOT);
    near(cnt[0], 3 * OSC);
    near(cnt[1], 2 * SLOT);
    near(cnt[2], OSC);
    near(cnt[3], 2 * SLOT - OSC);
    near(cnt[16], 3 * OSC);
  endtask : t_individual

  task automatic t_global;
    host.wr(MASTER_ADDR, 8'h01);
    global_intensity_en = 1'b1;
    blink = '{enable: 1'b1, flip: 1'b1, phase0: 17'h00008, phase1: 17'h00001};
    host.wr(MASTER_ADDR, 8'h11);
    wait_pwm();
    measure(SLOT);
    near(cnt[0], SLOT - 2 * OSC);
    near(cnt[1], 2 * OSC);
    near(cnt[3], 2 * OSC);
    near(cnt[16], 2 * OSC);
  endtask : t_global

  task automatic stop_test;
    $display("errors=%0d compares=%0d", err_total, compares);
    if (err_total == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : stop_test

  initial begin
    sys_rst = 1'b1;
    global_intensity_en = 1'b0;
    blink = '{enable: 1'b0, flip: 1'b0, phase0: 17'h00008, phase1: 17'h00000};
    repeat (16) @(negedge core_clk);
    sys_rst = 1'b0;
    t_static();
    t_individual();
    t_global();
    stop_test();
  end
endmodule : tb_top
